// ===== pkg/smc_pkg.sv
// package of constants and types for the sleep mode controller
package smc_pkg;

  // sleep mode select codes
  localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
  localparam logic [2:0] SMC_MODE_NOISE = 3'h1;
  localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
  localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
  localparam logic [2:0] SMC_MODE_RSV4 = 3'h4;
  localparam logic [2:0] SMC_MODE_RSV5 = 3'h5;
  localparam logic [2:0] SMC_MODE_STBY = 3'h6;
  localparam logic [2:0] SMC_MODE_XSTBY = 3'h7;

  // reset values of the control bits
  localparam logic SMC_SLEEP_ENABLE_RST = 1'h0;
  localparam logic [2:0] SMC_MODE_RST = 3'h0;
  localparam logic SMC_BOD_OFF_RST = 1'h0;

  // clock rate and timing
  localparam int SMC_CLK_MHZ = 10;
  localparam int SMC_HALT_CYCLES = 4;
  localparam int SMC_STBY_CYCLES = 6;
  localparam int SMC_BOD_WAKE_US = 60;
  localparam int SMC_BOD_WAKE_CYCLES = SMC_BOD_WAKE_US * SMC_CLK_MHZ;

  // width of the wake delay counter
  localparam int SMC_CNT_W = 16;

  // controller states
  typedef enum logic [2:0] {
    SMC_RUN,
    SMC_SLEEP,
    SMC_STARTUP,
    SMC_HALT
  } smc_state_type;

endpackage : smc_pkg

// ===== verilog/smc_delay_counter.sv
// down counter that times the wake-up start-up delay
module smc_delay_counter
  import smc_pkg::*;
#(
  parameter int WIDTH = SMC_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);

  logic [WIDTH-1:0] count; // remaining cycles

  // load on request, otherwise count down to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // done on the last cycle of the delay, so a load of n gives n cycles
  assign done = (count <= WIDTH'(1)) && !load;

endmodule : smc_delay_counter

// ===== verilog/smc_sleep_controller.sv
// sleep mode controller: entry, clock gating, wake sources, brown-out off
//
// Overview of operation
// - sleep only when enable bit set, instruction
// - mode select field picks entered mode
// - idle gates only core and flash clocks
// - noise mode stops io, core, flash clocks
// - noise mode entry starts conversion if enabled
// - noise mode wakes only on listed events
// - power-down stops oscillator and all clocks
// - power-down wakes only on listed events
// - deep modes: only level external irqs wake
// - interrupt wake halts core four extra cycles
// - register file and memory kept across sleep
// - reset during sleep restarts at reset vector
// - idle wakes on external and peripheral irqs
// - brown-out off only in deep modes
// - brown-out off at entry, back on wake
// - brown-out off lengthens wake to 60us
// - brown-out off bit resets to zero
// - brown-out bit written via timed sequence
// - level must hold through start-up for irq; checked in deep modes only
// - power-down wake waits clock-select start-up
// - power-save like power-down plus timer2
// - standby modes keep oscillator, six cycles unless brown-out off
module smc_sleep_controller
  import smc_pkg::*;
#(
  parameter int STARTUP_DEFAULT = 16,
  parameter int BOD_WAKE_CYCLES = SMC_BOD_WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic brownout_sleep_off_bit,
  input wire logic sleep_instr,
  input wire logic [SMC_CNT_W-1:0] startup_cycles,
  input wire logic converter_enabled,
  input wire logic timer2_async,
  input wire logic irq_global_enable,
  input wire logic external_irq_zero,
  input wire logic external_irq_one,
  input wire logic ext_irq_zero_level_mode,
  input wire logic ext_irq_one_level_mode,
  input wire logic pin_change_irq,
  input wire logic two_wire_addr_match,
  input wire logic timer2_irq,
  input wire logic watchdog_irq,
  input wire logic converter_done_irq,
  input wire logic store_ready_irq,
  input wire logic peripheral_irq,
  input wire logic reset_event,
  output logic core_clock_en,
  output logic flash_clock_en,
  output logic peripheral_io_clock_en,
  output logic converter_clock_en,
  output logic async_clock_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic brownout_detector_en,
  output logic converter_start,
  output logic core_halt,
  output logic irq_dispatch,
  output logic reset_vector_start,
  output logic sleeping
);

  smc_state_type state; // controller state
  smc_state_type next_state; // next controller state
  logic [2:0] mode; // mode latched at entry
  logic [2:0] gate_mode; // mode that the clock gates follow
  logic bod_off; // detector switched off for this sleep
  logic irq_wake; // wake came from an interrupt
  logic rst_wake; // wake came from a reset
  logic [5:0] sync1; // first stage for pin-side events
  logic [5:0] sync2; // second stage, the only one read
  logic ext0_s, ext1_s, pin_change_irq_s, twi_s, wdt_s, rst_s; // synced pins
  logic ext_level; // level-sensed external irq pending
  logic ext_any; // any external irq pending
  logic wake_any; // wake condition for the latched mode
  logic wake_is_irq; // wake by interrupt rather than reset
  logic deep; // power-down family of modes
  logic standby; // oscillator kept running
  logic reserved; // reserved code, nothing gated
  logic [SMC_CNT_W-1:0] delay; // wake delay to load
  logic cnt_load; // start the delay counter
  logic cnt_done; // delay elapsed
  logic enter; // legal sleep request this cycle
  logic [2:0] halt_cnt; // extra halt cycles after start-up

  // pins and async-domain events pass two flops before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {reset_event, watchdog_irq, two_wire_addr_match,
                pin_change_irq, external_irq_one, external_irq_zero};
      sync2 <= sync1;
    end
  end
  assign {rst_s, wdt_s, twi_s, pin_change_irq_s, ext1_s, ext0_s} = sync2;

  // mode classes of the latched mode
  assign reserved = (mode == SMC_MODE_RSV4) || (mode == SMC_MODE_RSV5);
  assign standby = (mode == SMC_MODE_STBY) || (mode == SMC_MODE_XSTBY);
  assign deep = (mode == SMC_MODE_PDOWN) || (mode == SMC_MODE_PSAVE)
      || standby;
  // at the entry edge the gates must follow the mode being entered
  assign gate_mode = (state == SMC_RUN) ? sleep_mode_select : mode;

  // edge-configured external pins are ignored outside idle
  assign ext_level = (ext0_s && ext_irq_zero_level_mode)
      || (ext1_s && ext_irq_one_level_mode);
  assign ext_any = ext0_s || ext1_s;

  // wake matrix per latched mode
  always_comb begin
    wake_is_irq = 1'b0;
    unique case (mode)
      SMC_MODE_IDLE: begin
        wake_is_irq = ext_any || pin_change_irq_s || twi_s || timer2_irq
            || store_ready_irq || converter_done_irq || wdt_s
            || peripheral_irq;
      end
      SMC_MODE_NOISE: begin
        wake_is_irq = converter_done_irq || wdt_s || twi_s
            || (timer2_irq && timer2_async) || store_ready_irq
            || ext_level || pin_change_irq_s;
      end
      SMC_MODE_PDOWN, SMC_MODE_STBY: begin
        wake_is_irq = wdt_s || twi_s || ext_level || pin_change_irq_s;
      end
      SMC_MODE_PSAVE, SMC_MODE_XSTBY: begin
        wake_is_irq = wdt_s || twi_s || ext_level || pin_change_irq_s
            || timer2_irq;
      end
      SMC_MODE_RSV4, SMC_MODE_RSV5: begin
        wake_is_irq = 1'b0;
      end
    endcase
  end
  // resets wake from every mode
  assign wake_any = wake_is_irq || rst_s;

  // sleep taken only with the enable bit set
  assign enter = sleep_instr && sleep_enable_bit;

  // wake delay: standby six cycles, brown-out off 60us, idle and noise one cycle, else fuses
  always_comb begin
    delay = (startup_cycles != '0) ? startup_cycles
        : SMC_CNT_W'(STARTUP_DEFAULT);
    if (bod_off) begin
      delay = SMC_CNT_W'(BOD_WAKE_CYCLES);
    end else if (standby) begin
      delay = SMC_CNT_W'(SMC_STBY_CYCLES);
    end else if (mode == SMC_MODE_IDLE || mode == SMC_MODE_NOISE) begin
      delay = SMC_CNT_W'(1);
    end
  end
  assign cnt_load = (state == SMC_SLEEP) && wake_any;

  // start-up timer, kept separate so it can be reused for resets
  smc_delay_counter #(
    .WIDTH(SMC_CNT_W)
  ) u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(cnt_load),
    .load_value(delay),
    .done(cnt_done)
  );

  // state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      SMC_RUN: begin
        if (enter) begin
          next_state = SMC_SLEEP;
        end
      end
      SMC_SLEEP: begin
        if (wake_any) begin
          next_state = SMC_STARTUP;
        end
      end
      SMC_STARTUP: begin
        if (cnt_done) begin
          next_state = rst_wake ? SMC_RUN : SMC_HALT;
        end
      end
      SMC_HALT: begin
        if (halt_cnt == 3'(SMC_HALT_CYCLES - 1)) begin
          next_state = SMC_RUN;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // mode and detector choice latched at entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= SMC_MODE_RST;
      bod_off <= SMC_BOD_OFF_RST;
    end else if (state == SMC_RUN && enter) begin
      mode <= sleep_mode_select;
      // eligible modes only; bit is written by a guarded sequence
      bod_off <= brownout_sleep_off_bit &&
          (sleep_mode_select == SMC_MODE_PDOWN
          || sleep_mode_select == SMC_MODE_PSAVE
          || sleep_mode_select == SMC_MODE_STBY
          || sleep_mode_select == SMC_MODE_XSTBY);
    end else if (state == SMC_RUN) begin
      bod_off <= 1'b0;
    end
  end

  // cause of wake, reset takes priority over interrupt
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_wake <= 1'b0;
      rst_wake <= 1'b0;
    end else if (state == SMC_SLEEP && wake_any) begin
      rst_wake <= rst_s;
      irq_wake <= !rst_s;
    end else if (state == SMC_RUN) begin
      irq_wake <= 1'b0;
      rst_wake <= 1'b0;
    end
  end

  // extra halt cycles after start-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      halt_cnt <= 3'h0;
    end else if (state == SMC_HALT) begin
      halt_cnt <= halt_cnt + 3'h1;
    end else begin
      halt_cnt <= 3'h0;
    end
  end

  // conversion kicked once at noise mode entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converter_start <= 1'b0;
    end else begin
      converter_start <= (state == SMC_RUN) && enter
          && (sleep_mode_select == SMC_MODE_NOISE)
          && converter_enabled;
    end
  end

  // one-cycle strobes at the end of wake; deep-mode level irq only if still held
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_dispatch <= 1'b0;
      reset_vector_start <= 1'b0;
    end else begin
      irq_dispatch <= (state == SMC_HALT) && (next_state == SMC_RUN)
          && irq_wake && irq_global_enable
          && (!deep || wake_is_irq);
      reset_vector_start <= (state == SMC_STARTUP) && cnt_done
          && rst_wake;
    end
  end

  // clock gating per latched mode; core state is frozen, not cleared
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_clock_en <= 1'b1;
      flash_clock_en <= 1'b1;
      peripheral_io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
    end else if (next_state != SMC_SLEEP || gate_mode == SMC_MODE_RSV4
        || gate_mode == SMC_MODE_RSV5) begin
      // awake, or reserved code: nothing gated
      core_clock_en <= 1'b1;
      flash_clock_en <= 1'b1;
      peripheral_io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
    end else begin
      core_clock_en <= 1'b0;
      flash_clock_en <= 1'b0;
      peripheral_io_clock_en <= (gate_mode == SMC_MODE_IDLE);
      converter_clock_en <= (gate_mode == SMC_MODE_IDLE)
          || (gate_mode == SMC_MODE_NOISE);
      async_clock_en <= (gate_mode == SMC_MODE_IDLE)
          || (gate_mode == SMC_MODE_NOISE) || (gate_mode == SMC_MODE_PSAVE)
          || (gate_mode == SMC_MODE_XSTBY && timer2_async);
      main_osc_en <= (gate_mode != SMC_MODE_PDOWN)
          && (gate_mode != SMC_MODE_PSAVE);
      timer_osc_en <= timer2_async && ((gate_mode == SMC_MODE_IDLE)
          || (gate_mode == SMC_MODE_NOISE) || (gate_mode == SMC_MODE_PSAVE)
          || (gate_mode == SMC_MODE_XSTBY));
    end
  end

  // detector off right after entry, on again at wake
  assign brownout_detector_en = !(bod_off && state == SMC_SLEEP);
  assign core_halt = (state != SMC_RUN);
  assign sleeping = (state == SMC_SLEEP);

  // checks
  a_no_sleep_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_RUN && sleep_instr && !sleep_enable_bit)
    |=> state == SMC_RUN) else $error("slept without enable");
  a_idle_gating: assert property (@(posedge clk) disable iff (sys_rst)
    (sleeping && mode == SMC_MODE_IDLE) |=> (!core_clock_en
    || !sleeping) && peripheral_io_clock_en)
    else $error("idle gating wrong");
  a_noise_gating: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_SLEEP && $past(state) == SMC_SLEEP
    && mode == SMC_MODE_NOISE) |-> !peripheral_io_clock_en
    && converter_clock_en) else $error("noise gating wrong");
  a_noise_start: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_RUN && enter && sleep_mode_select == SMC_MODE_NOISE
    && converter_enabled) |=> converter_start)
    else $error("no conversion start");
  a_pdown_osc: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_SLEEP && $past(state) == SMC_SLEEP
    && mode == SMC_MODE_PDOWN) |-> !main_osc_en && !async_clock_en)
    else $error("oscillator ran in power-down");
  a_edge_no_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_SLEEP && mode == SMC_MODE_PDOWN && !pin_change_irq_s
    && !twi_s && !wdt_s && !rst_s && !ext_level) |=> state == SMC_SLEEP)
    else $error("woke on edge irq");
  a_halt_four: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_STARTUP && cnt_done && !rst_wake)
    |=> (state == SMC_HALT) [*4] ##1 state == SMC_RUN)
    else $error("halt not four cycles");
  a_reset_vector: assert property (@(posedge clk) disable iff (sys_rst)
    (state == SMC_STARTUP && cnt_done && rst_wake)
    |=> reset_vector_start && !irq_dispatch)
    else $error("reset wake not to vector");
  a_bod_idle_on: assert property (@(posedge clk) disable iff (sys_rst)
    (sleeping && (mode == SMC_MODE_IDLE || mode == SMC_MODE_NOISE))
    |-> brownout_detector_en) else $error("detector off in idle");
  a_bod_back_on: assert property (@(posedge clk) disable iff (sys_rst)
    (sleeping && !$past(sleeping) && bod_off) |-> !brownout_detector_en
    ##1 (sleeping || brownout_detector_en))
    else $error("detector not managed");
  a_reserved_open: assert property (@(posedge clk) disable iff (sys_rst)
    (sleeping && reserved) |-> core_clock_en && main_osc_en)
    else $error("reserved code gated");

  c_idle_wake: cover property (@(posedge clk) disable iff (sys_rst)
    sleeping && mode == SMC_MODE_IDLE ##1 state == SMC_STARTUP);
  c_pdown_irq: cover property (@(posedge clk) disable iff (sys_rst)
    irq_dispatch && mode == SMC_MODE_PDOWN);
  c_bod_off: cover property (@(posedge clk) disable iff (sys_rst)
    sleeping && !brownout_detector_en);
  c_reset_wake: cover property (@(posedge clk) disable iff (sys_rst)
    reset_vector_start);

endmodule : smc_sleep_controller

// ===== sim/smc_wake_model.sv
// behavioural wake event sources facing the controller
module smc_wake_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] src,
  input wire logic [15:0] hold,
  output logic [9:0] wake,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = 16'h0000; // cycles the event still stands
  logic [3:0] cur = 4'h0; // index of the active event
  // one event at a time keeps each wake cause unambiguous
  always @(posedge clk) begin
    if (go && !busy) begin
      cur <= src;
      left <= hold;
    end else if (left > 16'h0001) begin
      left <= left - 16'h0001;
    end else begin
      left <= 16'h0000;
    end
  end
  // released lines return to their quiet low level
  assign busy = left != 16'h0000;
  assign wake = busy ? (10'h001 << cur) : 10'h000;
endmodule : smc_wake_model

// ===== sim/tb_smc_sleep_controller.sv
// testbench of the sleep mode controller with queued expectations
module tb_smc_sleep_controller import smc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BODC = 20; // shortened detector wake time
  typedef struct {
    logic [6:0] clks;
    logic brownout_detector;
    logic cs;
    logic [1:0] kind;
    int cnt;
  } smc_note_type;
  smc_note_type notes[$]; // oldest expectation first
  logic clk = 1'b0, sys_rst = 1'b1, sleep_enable_bit = 1'b0;
  logic [2:0] sleep_mode_select = 3'h0;
  logic brownout_sleep_off_bit = 1'b0, sleep_instr = 1'b0, go = 1'b0;
  logic [15:0] startup_cycles = 16'h0004, hold = 16'h0001;
  logic conv_en = 1'b0, t2a = 1'b0, lvl0 = 1'b1, lvl1 = 1'b1, gie = 1'b1;
  logic [3:0] src = 4'h0;
  logic [9:0] wake;
  logic [6:0] clks; // core flash io adc async main timer
  logic bod_en, conv_start, core_halt, irq_disp, rst_vec, sleeping, busy;
  logic cs_seen = 1'b0, prev_halt = 1'b0, prev_sleep = 1'b0;
  int errors = 0, tests_run = 0, cycles = 0, cnt = 0;
  always #50 clk = ~clk;
  smc_sleep_controller #(.BOD_WAKE_CYCLES(BODC)) smc_sleep_controller_i (
    .clk(clk), .sys_rst(sys_rst), .sleep_enable_bit(sleep_enable_bit),
    .sleep_mode_select(sleep_mode_select),
    .brownout_sleep_off_bit(brownout_sleep_off_bit),
    .sleep_instr(sleep_instr), .startup_cycles(startup_cycles),
    .converter_enabled(conv_en), .timer2_async(t2a),
    .irq_global_enable(gie), .external_irq_zero(wake[0]),
    .external_irq_one(wake[1]), .ext_irq_zero_level_mode(lvl0),
    .ext_irq_one_level_mode(lvl1), .pin_change_irq(wake[2]),
    .two_wire_addr_match(wake[3]), .timer2_irq(wake[4]),
    .watchdog_irq(wake[5]), .converter_done_irq(wake[6]),
    .store_ready_irq(wake[7]), .peripheral_irq(wake[8]),
    .reset_event(wake[9]), .core_clock_en(clks[6]),
    .flash_clock_en(clks[5]), .peripheral_io_clock_en(clks[4]),
    .converter_clock_en(clks[3]), .async_clock_en(clks[2]),
    .main_osc_en(clks[1]), .timer_osc_en(clks[0]),
    .brownout_detector_en(bod_en), .converter_start(conv_start),
    .core_halt(core_halt), .irq_dispatch(irq_disp),
    .reset_vector_start(rst_vec), .sleeping(sleeping)
  );
  smc_wake_model smc_wake_model_i (.clk(clk), .go(go), .src(src),
    .hold(hold), .wake(wake), .busy(busy));
  // single comparison point, counts every compare
  task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  function automatic bit deep(logic [2:0] m);
    return m inside {SMC_MODE_PDOWN, SMC_MODE_PSAVE, SMC_MODE_STBY,
      SMC_MODE_XSTBY};
  endfunction : deep
  // which source index may end sleep in a mode; 9 is a reset
  function automatic bit allowed(logic [2:0] m, int s);
    if (s == 9 || m == SMC_MODE_IDLE) return 1'b1;
    if (m inside {SMC_MODE_RSV4, SMC_MODE_RSV5}) return 1'b0;
    case (s)
      0: return lvl0;
      1: return lvl1;
      2, 3, 5: return 1'b1;
      4: return m == SMC_MODE_NOISE ? t2a : m[0];
      6, 7: return m == SMC_MODE_NOISE;
      default: return 1'b0;
    endcase
  endfunction : allowed
  function automatic logic [6:0] gates(logic [2:0] m);
    case (m)
      SMC_MODE_IDLE: return {6'h0f, t2a};
      SMC_MODE_NOISE: return {6'h07, t2a};
      SMC_MODE_PDOWN: return 7'h00;
      SMC_MODE_PSAVE: return {6'h02, t2a};
      SMC_MODE_STBY: return 7'h02;
      SMC_MODE_XSTBY: return {4'h0, t2a, 1'b1, t2a};
      default: return 7'h7f;
    endcase
  endfunction : gates
  function automatic int delay(logic [2:0] m, logic b);
    if (b && deep(m)) return BODC;
    if (m inside {SMC_MODE_STBY, SMC_MODE_XSTBY}) return SMC_STBY_CYCLES;
    if (m inside {SMC_MODE_IDLE, SMC_MODE_NOISE}) return 1;
    return int'(startup_cycles);
  endfunction : delay
  task automatic raise(int s, int h);
    @(negedge clk);
    src = 4'(s);
    hold = 16'(h);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
  endtask : raise
  // one sleep: optional refused source, then a real wake
  task automatic round(logic [2:0] m, logic b, int bad, int good, int h);
    int n;
    logic [1:0] k;
    gie = 1'($urandom);
    k = good == 9 ? 2'h1 : (h >= 200 && gie ? 2'h2 : 2'h0);
    @(negedge clk);
    sleep_mode_select = m;
    brownout_sleep_off_bit = b;
    sleep_enable_bit = 1'b1;
    notes.push_back('{gates(m), !(b && deep(m)),
      m == SMC_MODE_NOISE && conv_en, k,
      delay(m, b) + (good == 9 ? 0 : SMC_HALT_CYCLES)});
    sleep_instr = 1'b1;
    @(negedge clk);
    sleep_instr = 1'b0;
    repeat (3) @(negedge clk);
    check(sleeping, 1, "sleep not entered");
    if (bad >= 0) begin
      raise(bad, 8);
      repeat (12) @(negedge clk);
      check(sleeping, 1, "woke on a blocked source");
    end
    raise(good, good == 9 ? 4 : h);
    n = 0;
    while (core_halt !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    check(n < 500, 1, "no wake");
    while (busy) @(negedge clk);
  endtask : round
  // result watcher: checks at sleep entry and at the end of halt
  always @(negedge clk) begin
    if (!sys_rst) begin
      if (conv_start) cs_seen = 1'b1;
      if (sleeping && !prev_sleep && notes.size() > 0) begin
        check(clks, notes[0].clks, "clock gating");
        check(bod_en, notes[0].brownout_detector, "detector in sleep");
      end
      if (core_halt && !sleeping) cnt++;
      if (!core_halt && prev_halt && notes.size() > 0) begin
        check({irq_disp, rst_vec}, notes[0].kind, "wake kind");
        check(cnt, notes[0].cnt, "wake time");
        check(cs_seen, notes[0].cs, "conversion start");
        check(bod_en, 1, "detector not back");
        void'(notes.pop_front());
        cnt = 0;
        cs_seen = 1'b0;
      end
      prev_sleep = sleeping;
      prev_halt = core_halt;
    end
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    int bad, good;
    void'($urandom(35));
    startup_cycles = 16'(2 + $urandom % 10);
    conv_en = 1'($urandom);
    t2a = 1'($urandom);
    lvl0 = 1'($urandom);
    lvl1 = 1'($urandom);
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    sleep_instr = 1'b1;
    @(negedge clk);
    sleep_instr = 1'b0;
    repeat (3) @(negedge clk);
    check(sleeping, 0, "slept with enable clear");
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 8; m++) begin
        bad = -1;
        if (m != 0) begin
          do bad = $urandom % 9; while (allowed(3'(m), bad));
        end
        do good = $urandom % 10;
        while (!allowed(3'(m), good) || (good == 9 && m < 4 && r > 0));
        round(3'(m), 1'($urandom), bad, good, 200);
      end
    end
    // level released before start-up ends: silent wake
    lvl0 = 1'b1;
    round(SMC_MODE_PDOWN, 1'b0, -1, 0, 3);
    summarize();
  end
endmodule : tb_smc_sleep_controller
